/* mpr_cal_pkg.sv */
package mpr_cal_pkg;

  // command encoding on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam logic [3:0] CMD_WRITE = 4'h4;

  // mode register selection on bank address
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;

  // field positions
  localparam int MR3_EN_BIT = 2;
  localparam int MR3_SEL_LSB = 0;
  localparam int A_BC_BIT = 12;
  localparam int A_ZQL_BIT = 10;
  localparam int A_NIB_BIT = 2;
  localparam int MR0_CL_LSB = 4;
  localparam int MR1_AL_LSB = 3;

  localparam logic [1:0] MR3_SEL_PATTERN = 2'h0;
  localparam logic [1:0] MR0_BL_FIXED8 = 2'h0;
  localparam logic [1:0] MR0_BL_OTF = 2'h1;
  localparam logic [13:0] MR_RESET = 14'h0000;
  localparam logic [7:0] PATTERN_WORD = 8'hAA;

  // calibration windows and burst lengths in clock cycles
  localparam int ZQINIT_CYC = 512;
  localparam int ZQOPER_CYC = 256;
  localparam int ZQCS_CYC = 64;
  localparam int BURST_BEATS = 8;
  localparam int CHOP_BEATS = 4;

  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 5;

  typedef struct packed {
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [13:0] addr;
  } cmd_bus_t;

  // one burst request queued for readout
  typedef struct packed {
    logic chop;
    logic nibble;
    logic pattern;
    logic [1:0] spare;
  } burst_req_t;

endpackage : mpr_cal_pkg

/* burst_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module burst_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = wr_reg == rd_reg;
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : burst_fifo
`default_nettype wire

/* mpr_cal_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module mpr_cal_dev (
  input wire logic clk,
  input wire logic rstn,
  input wire mpr_cal_pkg::cmd_bus_t cmd_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  output logic dqs_out,
  output logic data_valid,
  output logic zq_busy,
  output logic pattern_mode,
  output logic [13:0] mr0_value,
  output logic [13:0] mr1_value,
  output logic [13:0] mr2_value,
  output logic [13:0] mr3_value,
  output logic cmd_error,
  output logic queue_full
);
  ////////////////////////////////////////////////////////////////////////
  // command decode
  logic [13:0] mr0_reg, mr1_reg, mr2_reg, mr3_reg;
  wire is_mrs = cmd_in.cmd == mpr_cal_pkg::CMD_MRS;
  wire is_read = cmd_in.cmd == mpr_cal_pkg::CMD_READ;
  wire is_zq = cmd_in.cmd == mpr_cal_pkg::CMD_ZQ;
  wire is_write = cmd_in.cmd == mpr_cal_pkg::CMD_WRITE;
  wire mpr_en = mr3_reg[mpr_cal_pkg::MR3_EN_BIT];
  wire [1:0] mpr_sel = mr3_reg[mpr_cal_pkg::MR3_SEL_LSB +: 2];
  wire [1:0] bl_mode = mr0_reg[1:0];
  // on-the-fly: a12 high means full burst; fixed modes ignore a12
  wire chop = (bl_mode == mpr_cal_pkg::MR0_BL_OTF) ? !cmd_in.addr[mpr_cal_pkg::A_BC_BIT]
                                                   : (bl_mode != mpr_cal_pkg::MR0_BL_FIXED8);
  wire [4:0] cl = 5'(mr0_reg[mpr_cal_pkg::MR0_CL_LSB +: 3]) + 5'h4;
  wire [4:0] al = 5'(mr1_reg[mpr_cal_pkg::MR1_AL_LSB +: 2]);
  wire [5:0] rl = 6'(cl) + 6'(al);
  // reserved selector codes read out as driven all-zero beats
  wire pat_ok = mpr_sel == mpr_cal_pkg::MR3_SEL_PATTERN;

  ////////////////////////////////////////////////////////////////////////
  // read latency pipeline feeding the queue
  logic [63:0] lat_pipe_reg;
  logic [4:0] req_pipe_reg [64];
  wire mpr_read = is_read && mpr_en && !zq_busy;
  mpr_cal_pkg::burst_req_t req_new;
  assign req_new = '{chop: chop, nibble: cmd_in.addr[mpr_cal_pkg::A_NIB_BIT],
                     pattern: pat_ok, spare: 2'h0};
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [4:0] fifo_out_data;
  logic burst_active_reg;
  logic [2:0] beat_reg;
  logic [2:0] last_reg;
  logic pat_reg;
  wire burst_done = burst_active_reg && (beat_reg == last_reg);
  wire fifo_pop = fifo_out_valid && (!burst_active_reg || burst_done);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lat_pipe_reg <= 64'h0000000000000000;
    end else begin
      // a request walks down one slot per clock and leaves at slot 0
      lat_pipe_reg <= {1'b0, lat_pipe_reg[63:1]} | (64'(mpr_read) << (rl - 6'h1));
    end
  end


  // payload moves in step with its valid bit; slot 63 is never loaded
  // a new read wins over the shifted slot, which is empty for one rl
  always_ff @(posedge clk) begin
    for (int i = 0; i < 63; i++) begin
      req_pipe_reg[i] <= req_pipe_reg[i + 1];
    end
    if (mpr_read) req_pipe_reg[rl - 6'h1] <= req_new;
  end


  burst_fifo #(.WIDTH(mpr_cal_pkg::FIFO_WIDTH), .DEPTH(mpr_cal_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(lat_pipe_reg[0]),
    .in_ready(fifo_in_ready),
    .in_data(req_pipe_reg[0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  mpr_cal_pkg::burst_req_t head;
  assign head = fifo_out_data;
  // beat index: chop with a2 set starts at position 4
  wire [2:0] first_beat = (head.chop && head.nibble) ? 3'h4 : 3'h0;
  wire [2:0] last_beat = head.chop ? (first_beat + 3'h3) : 3'h7;
  // pattern bit per beat: 0,1,0,1 so odd beats are one
  wire [7:0] beat_word = pat_reg ? {8{mpr_cal_pkg::PATTERN_WORD[beat_reg]}} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // mode registers, calibration timer, burst output
  logic [9:0] zq_cnt_reg;
  logic [7:0] dq_loop_unused;
  assign dq_loop_unused = dq_in;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mr0_reg <= mpr_cal_pkg::MR_RESET;
      mr1_reg <= mpr_cal_pkg::MR_RESET;
      mr2_reg <= mpr_cal_pkg::MR_RESET;
      mr3_reg <= mpr_cal_pkg::MR_RESET;
      zq_cnt_reg <= 10'h000;
      cmd_error <= 1'b0;
    end else begin
      if (is_mrs && !zq_busy) begin
        case (cmd_in.ba)
          mpr_cal_pkg::BA_MR0: mr0_reg <= cmd_in.addr;
          mpr_cal_pkg::BA_MR1: mr1_reg <= cmd_in.addr;
          mpr_cal_pkg::BA_MR2: mr2_reg <= cmd_in.addr;
          mpr_cal_pkg::BA_MR3: mr3_reg <= cmd_in.addr;
          default: ;
        endcase
      end
      // a new zq command restarts the window; long or short by a10
      if (is_zq) begin
        zq_cnt_reg <= cmd_in.addr[mpr_cal_pkg::A_ZQL_BIT] ? 10'(mpr_cal_pkg::ZQOPER_CYC)
                                                          : 10'(mpr_cal_pkg::ZQCS_CYC);
      end else if (zq_cnt_reg != 10'h000) begin
        zq_cnt_reg <= zq_cnt_reg - 10'h001;
      end
      // flags a write or bad read during pattern mode, sticky to reset
      if (mpr_en && (is_write || (is_read && !fifo_in_ready))) cmd_error <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      burst_active_reg <= 1'b0;
      beat_reg <= 3'h0;
      last_reg <= 3'h0;
      pat_reg <= 1'b0;
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
      dqs_out <= 1'b0;
      data_valid <= 1'b0;
    end else begin
      if (fifo_pop) begin
        burst_active_reg <= 1'b1;
        beat_reg <= first_beat;
        last_reg <= last_beat;
        pat_reg <= head.pattern;
      end else if (burst_done) begin
        burst_active_reg <= 1'b0;
      end else if (burst_active_reg) begin
        beat_reg <= beat_reg + 3'h1;
      end
      dq_out <= burst_active_reg ? beat_word : 8'h00;
      // bus stays released during calibration windows
      dq_oe_n <= !burst_active_reg || zq_busy;
      dqs_out <= burst_active_reg && !beat_reg[0];
      data_valid <= burst_active_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      zq_busy <= 1'b0;
      pattern_mode <= 1'b0;
      mr0_value <= mpr_cal_pkg::MR_RESET;
      mr1_value <= mpr_cal_pkg::MR_RESET;
      mr2_value <= mpr_cal_pkg::MR_RESET;
      mr3_value <= mpr_cal_pkg::MR_RESET;
      queue_full <= 1'b0;
    end else begin
      zq_busy <= is_zq || (zq_cnt_reg > 10'h001);
      pattern_mode <= mpr_en;
      mr0_value <= mr0_reg;
      mr1_value <= mr1_reg;
      mr2_value <= mr2_reg;
      mr3_value <= mr3_reg;
      queue_full <= !fifo_in_ready;
    end
  end
endmodule : mpr_cal_dev
`default_nettype wire

/* mpr_cal_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mpr_cal_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire mpr_cal_pkg::cmd_bus_t cmd_in,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic dqs_out,
  input wire logic data_valid,
  input wire logic zq_busy,
  input wire logic pattern_mode,
  input wire logic [13:0] mr0_value,
  input wire logic [13:0] mr3_value,
  input wire logic queue_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic mrs_ok = cmd_in.cmd == mpr_cal_pkg::CMD_MRS && !zq_busy;
  wire logic zq_cmd = cmd_in.cmd == mpr_cal_pkg::CMD_ZQ;
  wire logic rd_ok = cmd_in.cmd == mpr_cal_pkg::CMD_READ && pattern_mode && !zq_busy && !queue_full;
  wire logic sel0 = mr3_value[1:0] == mpr_cal_pkg::MR3_SEL_PATTERN;
  ////////////////////////////////////////////////////////////////////////////////
  a_even_beat: assert property (data_valid && dqs_out |-> dq_out == 8'h00)
    else $error("even beat not low");
  a_odd_beat: assert property (data_valid && !dqs_out && sel0 |-> dq_out == 8'hFF)
    else $error("odd beat not high");
  a_reserved_zero: assert property (data_valid && !sel0 |-> dq_out == 8'h00)
    else $error("reserved selector gave data");
  a_burst_drive: assert property ($rose(data_valid) |-> (data_valid && !dq_oe_n)[*4])
    else $error("burst shorter than a nibble");
  // mode register outputs trail the internal load by one clock
  a_mr0_load: assert property (mrs_ok && cmd_in.ba == mpr_cal_pkg::BA_MR0
    |=> ##1 mr0_value == $past(cmd_in.addr, 2)) else $error("mr0 not loaded");
  a_mr3_load: assert property (mrs_ok && cmd_in.ba == mpr_cal_pkg::BA_MR3
    |=> ##1 mr3_value == $past(cmd_in.addr, 2)) else $error("mr3 not loaded");
  // queued bursts may delay the answer by up to eight bursts
  a_read_latency: assert property (rd_ok |-> ##[6:120] data_valid)
    else $error("pattern read not answered");
  a_zq_long: assert property (zq_cmd && cmd_in.addr[mpr_cal_pkg::A_ZQL_BIT]
    |-> ##256 zq_busy ##1 !zq_busy) else $error("long calibration window wrong");
  a_zq_short: assert property (zq_cmd && !cmd_in.addr[mpr_cal_pkg::A_ZQL_BIT]
    |-> ##64 zq_busy ##1 !zq_busy) else $error("short calibration window wrong");
  c_read: cover property (rd_ok);
  c_zq: cover property ($rose(zq_busy));
  c_full: cover property ($rose(queue_full));
endmodule : mpr_cal_chk
bind mpr_cal_dev mpr_cal_chk i_mpr_cal_chk (.clk, .rstn, .cmd_in, .dq_out, .dq_oe_n, .dqs_out,
  .data_valid, .zq_busy, .pattern_mode, .mr0_value, .mr3_value, .queue_full);
`default_nettype wire

/* ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// single rank, cke held, no termination or dll modelled
module ctl_model #(
  parameter int TMOD = 12
) (
  input wire logic clk,
  output var mpr_cal_pkg::cmd_bus_t cmd_in
);
  initial cmd_in = '{4'hF, 3'h0, 14'h0000};
  // never writes; deselect scrambles lines so a stale address is never read
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
    input int gap);
    @(posedge clk);
    #10;
    cmd_in = '{c, b, a};
    @(posedge clk);
    #10;
    cmd_in = '{4'hF, 3'($urandom), 14'($urandom)};
    // mode loads only from idle, then settle time
    repeat (c == mpr_cal_pkg::CMD_MRS ? TMOD : gap) @(posedge clk);
  endtask : issue
endmodule : ctl_model
`default_nettype wire

/* dram_mpr_mrs_zq_calibration_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_mpr_mrs_zq_calibration_tb;
  logic clk, rstn, dq_oe_n, dqs_out, data_valid, zq_busy, pattern_mode, cmd_error, queue_full;
  logic [7:0] dq_in, dq_out;
  logic [13:0] mr0_value, mr1_value, mr2_value, mr3_value;
  logic [13:0] v[4];
  // expected beat as {dq_oe_n, dqs_out, dq_out}
  logic [9:0] exp_q[$];
  wire mpr_cal_pkg::cmd_bus_t cmd_in;
  int err_count, tests_run, n;
  bit skip, full_seen, ch;
  ctl_model i_ctl_model (.clk, .cmd_in);
  mpr_cal_dev i_mpr_cal_dev (.clk, .rstn, .cmd_in, .dq_in, .dq_out, .dq_oe_n, .dqs_out,
    .data_valid, .zq_busy, .pattern_mode, .mr0_value, .mr1_value, .mr2_value, .mr3_value,
    .cmd_error, .queue_full);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) dq_in <= #10 8'($urandom);
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge clk) begin
    if (queue_full) full_seen = 1;
    if (rstn && data_valid && !skip) begin
      if (exp_q.size() == 0) cmp(14'h1, 14'h0);
      else cmp(14'({dq_oe_n, dqs_out, dq_out}), 14'(exp_q.pop_front()));
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task results;
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task bound(input int lim);
    if (n >= lim) begin
      err_count++;
      results();
    end
  endtask : bound
  task rd(input bit chop, input bit a2, input bit a12, input logic [1:0] sel, input int gap);
    logic [13:0] addr_w;
    addr_w = {1'b0, a12, 9'h000, a2, 2'h0};
    for (int p = 0; p < 8; p++) begin
      if (!chop || p[2] == a2) begin
        exp_q.push_back({1'b0, !p[0], ((sel == 2'h0 && p[0]) ? 8'hFF : 8'h00)});
      end
    end
    i_ctl_model.issue(mpr_cal_pkg::CMD_READ, 3'h0, addr_w, gap);
  endtask : rd
  task mrs(input logic [2:0] b, input logic [13:0] d);
    i_ctl_model.issue(mpr_cal_pkg::CMD_MRS, b, d, 0);
  endtask : mrs
  task idle;
    n = 0;
    while ((exp_q.size() != 0 || data_valid) && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    bound(500);
  endtask : idle
  task zq(input bit lng);
    i_ctl_model.issue(mpr_cal_pkg::CMD_ZQ, 3'h0, 14'(lng) << 10, 0);
    // a read inside the window must be refused
    if (lng) i_ctl_model.issue(mpr_cal_pkg::CMD_READ, 3'h0, 14'h1000, 0);
    n = lng ? 2 : 0;
    while (zq_busy && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    bound(600);
    cmp(14'(n - (lng ? 256 : 64) + 1), 14'h1);
  endtask : zq
  task rst;
    rstn = 0;
    repeat (8) @(posedge clk);
    #10;
    rstn = 1;
    cmp(14'({cmd_error, pattern_mode, zq_busy, queue_full, dq_oe_n}), 14'h1);
    cmp(mr0_value | mr1_value | mr2_value | mr3_value, 14'h0);
  endtask : rst
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 0;
    void'($urandom(32'hE340));
    rst();
    for (int i = 0; i < 4; i++) begin
      v[i] = 14'($urandom);
      mrs(3'(i), v[i]);
    end
    mrs(3'h5, ~v[0]);
    cmp(mr0_value, v[0]);
    cmp(mr1_value, v[1]);
    cmp(mr2_value, v[2]);
    cmp(mr3_value, v[3]);
    mrs(3'h1, 14'h0010);
    mrs(3'h0, 14'h0030);
    mrs(3'h3, 14'h0004);
    cmp(14'(pattern_mode), 14'h1);
    zq(1);
    zq(0);
    rd(0, 0, 1, 2'h0, 0);
    n = 0;
    while (!data_valid && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    bound(50);
    cmp(14'(n), 14'(3 + 4 + 2 + 2));
    idle();
    // every burst mode, both nibbles, back to back
    for (int m = 0; m < 3; m++) begin
      mrs(3'h0, 14'h0030 | 14'(m));
      for (int k = 0; k < 4; k++) begin
        ch = m == 2 || (m == 1 && !k[1]);
        rd(ch, ch & k[0], k[1], 2'h0, 3);
      end
      idle();
    end
    mrs(3'h0, 14'h0030);
    for (int s = 1; s < 4; s++) begin
      mrs(3'h3, 14'(4 + s));
      rd(0, 0, 1, 2'(s), 3);
      idle();
    end
    mrs(3'h3, 14'h0004);
    skip = 1;
    repeat (24) rd(0, 0, 1, 2'h0, 0);
    exp_q.delete();
    cmp(14'({cmd_error, full_seen}), 14'h3);
    repeat (16) @(posedge clk);
    idle();
    skip = 0;
    mrs(3'h3, 14'h0000);
    cmp(14'(pattern_mode), 14'h0);
    // array path is absent here, so any answer to this read is a mismatch
    i_ctl_model.issue(mpr_cal_pkg::CMD_READ, 3'h0, 14'h1000, 30);
    rst();
    results();
  end
endmodule : dram_mpr_mrs_zq_calibration_tb
`default_nettype wire
